/* axr_regs.sv */
// aux converter and pin level register bank on Avalon-MM
// ==========================================================
// Overview of operation
// R1: pin level register at 14h, eight bits, one per pin, reset 00h.
// R2: a pin set as output reads back 0 in the level register.
// R3: writing an input pin's level bit only stores it, pin untouched.
// R4: level bit 0 means low, 1 means high; outputs drive the stored bit.
// R5: direction bit 0 makes an output (reset), 1 an input.
// R6: aux setup register at 15h, reset 00h.
// R7: bits 7:6 choose data rate 10, 100, 400 or 800 SPS.
// R8: bits 5:3 choose reference: internal, input pairs 0/1, 2/3, 4/5, supplies.
// R9: software never writes reference codes 101 to 111.
// R10: bits 2:0 choose gain two to the code, 1 to 64.
// R11: after reset: internal reference, unity gain, slowest rate.
// R12: input select register at 16h, reset 01h: input 0 positive, input 1 negative.
// R13: positive codes 0 to 9 pick analog pins, 1010 the common pin.
// R14: positive codes 1011 to 1111: monitors, test signal, open.
// R15: negative field bits 3:0 uses same pin map, reset 0001.
// R16: negative codes 1011 to 1110 monitor negatives, 1111 open; here 1110 gives the test signal, as for the positive field.
// R17: gain code 111 is flagged reserved yet stored and read back.
// R18: setup and select registers read back exactly what was written.
//
// The Avalon-MM register port was left to the implementer.
`default_nettype none
`include "axr_consts.svh"
module axr_regs
	import axr_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [`AXR_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] gpio_in,
	output logic [7:0] gpio_out,
	output logic [7:0] gpio_oe_n,
	output axr_rate_t aux_rate_select,
	output logic [9:0] aux_rate_sps,
	output axr_ref_t aux_reference_select,
	output logic aux_reference_reserved,
	output logic [2:0] aux_gain_select,
	output logic [6:0] aux_gain_vv,
	output logic aux_gain_reserved,
	output axr_src_t aux_positive_src,
	output logic [3:0] aux_positive_index,
	output axr_src_t aux_negative_src,
	output logic [3:0] aux_negative_index
);
	// ==========================================================
	// register state
	logic [7:0] pin_level_bits_q;
	logic [7:0] direction_q;
	logic [7:0] setup_q;
	logic [7:0] input_sel_q;
	logic [7:0] gpio_in_q;
	axr_bus_state_t state_q;
	axr_src_t pos_src_d;
	axr_src_t neg_src_d;
	logic [3:0] pos_idx_d;
	logic [3:0] neg_idx_d;
	logic wr_take;
	logic [7:0] word_idx;
	logic [7:0] rd_data_d;
	logic pin_hit;
	logic dir_hit;
	logic setup_hit;
	logic sel_hit;
	logic accept_d;
	logic [1:0] rate_code;
	logic [2:0] ref_code;
	logic [2:0] gain_code;

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge_byte = be[0] ? wd[7:0] : old;
	endfunction

	function automatic logic [9:0] rate_to_sps(input logic [1:0] code);
		case (code)
			2'h0: rate_to_sps = 10'h00A;
			2'h1: rate_to_sps = 10'h064;
			2'h2: rate_to_sps = 10'h190;
			default: rate_to_sps = 10'h320;
		endcase
	endfunction

	// code 111 has no gain setting; it is stored but flagged
	function automatic logic gain_is_reserved(input logic [2:0] code);
		gain_is_reserved = code > `AXR_GAIN_MAX;
	endfunction

	function automatic logic [6:0] gain_to_vv(input logic [2:0] code);
		if (gain_is_reserved(code)) begin
			gain_to_vv = 7'h00;
		end else begin
			gain_to_vv = 7'(7'h01 << code);
		end
	endfunction

	function automatic logic ref_is_reserved(input logic [2:0] code);
		ref_is_reserved = code > `AXR_REF_AVDD;
	endfunction

	// ==========================================================
	// bus handshake: one wait cycle, answer on the second edge
	assign word_idx = avs_address[`AXR_ADDR_W-1:2];
	assign pin_hit = (word_idx == `AXR_IDX_PIN_LEVELS);
	assign dir_hit = (word_idx == `AXR_IDX_DIRECTION);
	assign setup_hit = (word_idx == `AXR_IDX_SETUP);
	assign sel_hit = (word_idx == `AXR_IDX_INPUT_SEL);
	assign accept_d = (avs_read || avs_write) && (state_q == AXR_IDLE);
	assign wr_take = avs_write && (state_q == AXR_ACK);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= AXR_IDLE;
		end else begin
			case (state_q)
				AXR_IDLE: begin
					if (accept_d) begin
						state_q <= AXR_ACK;
					end
				end
				AXR_ACK: state_q <= AXR_IDLE;
				default: state_q <= AXR_IDLE;
			endcase
		end
	end

	// low for exactly the cycle in which the request is answered
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
		end else if (accept_d) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ==========================================================
	// pin sampling
	// one stage: pins are taken as synchronous
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gpio_in_q <= 8'h00;
		end else begin
			gpio_in_q <= gpio_in;
		end
	end

	// ==========================================================
	// register writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_level_bits_q <= `AXR_RST_PIN_LEVELS; // R1
		end else if (wr_take && pin_hit) begin
			pin_level_bits_q <= merge_byte(pin_level_bits_q, avs_writedata, avs_byteenable); // R3
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			direction_q <= `AXR_RST_DIRECTION; // R5
		end else if (wr_take && dir_hit) begin
			direction_q <= merge_byte(direction_q, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			setup_q <= `AXR_RST_SETUP; // R6 R11
		end else if (wr_take && setup_hit) begin
			setup_q <= merge_byte(setup_q, avs_writedata, avs_byteenable); // R17 R18
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			input_sel_q <= `AXR_RST_INPUT_SEL; // R12 R15
		end else if (wr_take && sel_hit) begin
			input_sel_q <= merge_byte(input_sel_q, avs_writedata, avs_byteenable); // R18
		end
	end

	// ==========================================================
	// read mux
	// inputs read the sampled pin, outputs read zero
	always_comb begin
		if (pin_hit) begin
			rd_data_d = gpio_in_q & direction_q; // R2 R4
		end else if (dir_hit) begin
			rd_data_d = direction_q;
		end else if (setup_hit) begin
			rd_data_d = setup_q; // R18
		end else if (sel_hit) begin
			rd_data_d = input_sel_q; // R18
		end else begin
			rd_data_d = 8'h00;
		end
	end

	// captured at the accept edge, stands until the next read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= `AXR_UNMAPPED_DATA;
		end else if (avs_read && accept_d) begin
			avs_readdata <= {24'h000000, rd_data_d};
		end
	end

	// ==========================================================
	// pin drive
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gpio_out <= 8'h00;
		end else begin
			gpio_out <= pin_level_bits_q & ~direction_q; // R3 R4
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gpio_oe_n <= 8'h00;
		end else begin
			gpio_oe_n <= direction_q; // R5
		end
	end

	// ==========================================================
	// decoded converter settings
	// every decoded output lags its register by one clock
	assign rate_code = setup_q[`AXR_RATE_HI:`AXR_RATE_LO];
	assign ref_code = setup_q[`AXR_REF_HI:`AXR_REF_LO];
	assign gain_code = setup_q[`AXR_GAIN_HI:`AXR_GAIN_LO];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_rate_select <= AXR_RATE_10;
			aux_rate_sps <= 10'h00A;
		end else begin
			aux_rate_select <= axr_rate_t'(rate_code); // R7
			aux_rate_sps <= rate_to_sps(rate_code); // R7
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_reference_select <= AXR_REF_INTERNAL;
			aux_reference_reserved <= 1'b0;
		end else begin
			aux_reference_select <= axr_ref_t'(ref_code); // R8
			aux_reference_reserved <= ref_is_reserved(ref_code);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_gain_select <= 3'h0;
			aux_gain_vv <= 7'h01;
			aux_gain_reserved <= 1'b0;
		end else begin
			aux_gain_select <= gain_code; // R10
			aux_gain_vv <= gain_to_vv(gain_code); // R10
			aux_gain_reserved <= gain_is_reserved(gain_code); // R17
		end
	end

	// ==========================================================
	// input select outputs
	axr_input_decode u_pos (
		.code(input_sel_q[`AXR_POS_HI:`AXR_POS_LO]),
		.src(pos_src_d),
		.index(pos_idx_d)
	);

	axr_input_decode u_neg (
		.code(input_sel_q[`AXR_NEG_HI:`AXR_NEG_LO]),
		.src(neg_src_d),
		.index(neg_idx_d)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_positive_src <= AXR_SRC_PIN;
			aux_positive_index <= 4'h0;
		end else begin
			aux_positive_src <= pos_src_d; // R13 R14
			aux_positive_index <= pos_idx_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aux_negative_src <= AXR_SRC_PIN;
			aux_negative_index <= 4'h1;
		end else begin
			aux_negative_src <= neg_src_d; // R15 R16
			aux_negative_index <= neg_idx_d;
		end
	end

endmodule // axr_regs
`default_nettype wire

/* axr_consts.svh */
// register offsets, field positions, reset values and codes for the aux register bank
`ifndef AXR_CONSTS_SVH
`define AXR_CONSTS_SVH

// documented offsets (indices); byte address is four times the index
`define AXR_IDX_PIN_LEVELS 8'h14
`define AXR_IDX_SETUP 8'h15
`define AXR_IDX_INPUT_SEL 8'h16
// own register for pin direction
`define AXR_IDX_DIRECTION 8'h13

`define AXR_RST_PIN_LEVELS 8'h00
`define AXR_RST_SETUP 8'h00
`define AXR_RST_INPUT_SEL 8'h01
`define AXR_RST_DIRECTION 8'h00

`define AXR_RATE_HI 7
`define AXR_RATE_LO 6
`define AXR_REF_HI 5
`define AXR_REF_LO 3
`define AXR_GAIN_HI 2
`define AXR_GAIN_LO 0
`define AXR_POS_HI 7
`define AXR_POS_LO 4
`define AXR_NEG_HI 3
`define AXR_NEG_LO 0

`define AXR_REF_AVDD 3'h4
`define AXR_GAIN_MAX 3'h6
`define AXR_SEL_PIN_LAST 4'hA

`define AXR_ADDR_W 10
`define AXR_UNMAPPED_DATA 32'h00000000

`endif

/* axr_pkg.sv */
// types for the aux register bank
`default_nettype none
package axr_pkg;
	typedef enum logic [1:0] {AXR_RATE_10, AXR_RATE_100, AXR_RATE_400, AXR_RATE_800} axr_rate_t;
	typedef enum logic [2:0] {
		AXR_REF_INTERNAL, AXR_REF_AIN01, AXR_REF_AIN23, AXR_REF_AIN45, AXR_REF_SUPPLY,
		AXR_REF_RSV5, AXR_REF_RSV6, AXR_REF_RSV7
	} axr_ref_t;
	typedef enum logic [1:0] {AXR_SRC_PIN, AXR_SRC_MONITOR, AXR_SRC_TEST, AXR_SRC_OPEN} axr_src_t;
	typedef enum {AXR_IDLE, AXR_ACK} axr_bus_state_t;
endpackage
`default_nettype wire

/* axr_input_decode.sv */
// decodes one input-select field into source kind and pin or monitor index
`default_nettype none
`include "axr_consts.svh"
module axr_input_decode
	import axr_pkg::*;
(
	input wire logic [3:0] code,
	output axr_src_t src,
	output logic [3:0] index
);
	always_comb begin
		index = code;
		if (code <= `AXR_SEL_PIN_LAST) begin
			src = AXR_SRC_PIN; // R13
		end else if (code == 4'hF) begin
			src = AXR_SRC_OPEN; // R14
			index = 4'h0;
		end else if (code == 4'hE) begin
			src = AXR_SRC_TEST;
			index = 4'h0;
		end else begin
			src = AXR_SRC_MONITOR; // R16
			index = code - 4'hB;
		end
	end
endmodule // axr_input_decode
`default_nettype wire

/* axr_regs_chk.sv */
// concurrent checks on the aux register bank ports
`default_nettype none
module axr_regs_chk import axr_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [7:0] gpio_out,
	input wire logic [7:0] gpio_oe_n,
	input wire axr_rate_t aux_rate_select,
	input wire logic [9:0] aux_rate_sps,
	input wire axr_ref_t aux_reference_select,
	input wire logic aux_reference_reserved,
	input wire logic [2:0] aux_gain_select,
	input wire logic [6:0] aux_gain_vv,
	input wire logic aux_gain_reserved
);
	// ==========================================================
	// bus handshake
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	req_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |->
		##[1:2] !avs_waitrequest)
		else $error("request not accepted in time");
	wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("accept held too long");
	ack_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("accept without request");
	rd_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	// ==========================================================
	// pins and decoded setup
	pin_drive_a: assert property ((gpio_out & gpio_oe_n) == 8'h00)
		else $error("input pin driven");
	gain_vv_a: assert property ($stable(aux_gain_select) |->
		aux_gain_vv == (aux_gain_select == 3'h7 ? 7'h00 : 7'h01 << aux_gain_select))
		else $error("gain decode wrong");
	gain_rsv_a: assert property ($stable(aux_gain_select) |->
		aux_gain_reserved == (aux_gain_select == 3'h7))
		else $error("gain reserved flag wrong");
	rate_sps_a: assert property ($stable(aux_rate_select) |-> aux_rate_sps ==
		(aux_rate_select == 2'h0 ? 10'h00A : aux_rate_select == 2'h1 ? 10'h064 :
		aux_rate_select == 2'h2 ? 10'h190 : 10'h320))
		else $error("rate decode wrong");
	ref_rsv_a: assert property ($stable(aux_reference_select) |->
		aux_reference_reserved == (aux_reference_select > 3'h4))
		else $error("reference reserved flag wrong");
	rd_cov: cover property (avs_read && !avs_waitrequest);
	wr_cov: cover property (avs_write && !avs_waitrequest);
	g7_cov: cover property (aux_gain_select == 3'h7);
endmodule // axr_regs_chk
bind axr_regs axr_regs_chk u_chk (.clk, .nrst, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .gpio_out, .gpio_oe_n, .aux_rate_select, .aux_rate_sps,
	.aux_reference_select, .aux_reference_reserved, .aux_gain_select, .aux_gain_vv,
	.aux_gain_reserved);
`default_nettype wire

/* axr_regs_tb.sv */
// self-checking testbench for the aux register bank
`default_nettype none
`include "axr_consts.svh"
module axr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, rd_s, wr_s, wt, rr, gr;
	logic [9:0] adr, sps;
	logic [31:0] wd, rdat;
	logic [3:0] be, pi, ni;
	logic [7:0] gin, gout, goe, rv;
	logic [1:0] rs, ps, ns;
	logic [2:0] rf, gs;
	logic [6:0] gv;
	int n_errors, checks;
	axr_regs DUT (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd_s),
		.avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wt), .gpio_in(gin), .gpio_out(gout), .gpio_oe_n(goe),
		.aux_rate_select(rs), .aux_rate_sps(sps), .aux_reference_select(rf),
		.aux_reference_reserved(rr), .aux_gain_select(gs), .aux_gain_vv(gv),
		.aux_gain_reserved(gr), .aux_positive_src(ps), .aux_positive_index(pi),
		.aux_negative_src(ns), .aux_negative_index(ni));
	// ==========================================================
	// helpers
	task end_sim;
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		@(posedge clk);
		adr <= {i, 2'b00};
		wd <= {24'h000000, d};
		wr_s <= w;
		rd_s <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 50);
		if (wt !== 1'b0) begin
			n_errors++;
			end_sim();
		end
		rv = rdat[7:0];
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task settle;
		repeat (2) @(negedge clk);
	endtask
	function automatic logic [5:0] ex(input logic [3:0] c);
		return c <= 4'hA ? {2'h0, c} : c <= 4'hD ? {2'h1, c - 4'hB} : {c == 4'hE ? 2'h2 : 2'h3, 4'h0};
	endfunction
	// ==========================================================
	// scenarios
	task t_reset;
		bus(0, `AXR_IDX_PIN_LEVELS, 8'h00);
		chk(rv, 8'h00);
		bus(0, `AXR_IDX_SETUP, 8'h00);
		chk(rv, 8'h00);
		bus(0, `AXR_IDX_INPUT_SEL, 8'h00);
		chk(rv, 8'h01);
		chk({sps, gv, rf}, {10'h00A, 7'h01, 3'h0});
		chk({ps, pi, ns, ni}, 12'h001);
	endtask
	task t_gpio;
		bus(1, `AXR_IDX_PIN_LEVELS, 8'hA5);
		settle();
		chk({goe, gout}, 16'h00A5);
		bus(0, `AXR_IDX_PIN_LEVELS, 8'h00);
		chk(rv, 8'h00);
		gin <= 8'h3C;
		bus(1, `AXR_IDX_DIRECTION, 8'hF0);
		settle();
		chk({goe, gout}, 16'hF005);
		bus(0, `AXR_IDX_PIN_LEVELS, 8'h00);
		chk(rv, 8'h30);
		bus(1, `AXR_IDX_PIN_LEVELS, 8'hFF);
		settle();
		chk(gout, 8'h0F);
		bus(1, `AXR_IDX_DIRECTION, 8'h00);
		settle();
		chk(gout, 8'hFF);
	endtask
	task t_setup;
		logic [9:0] t[4];
		logic [2:0] r;
		t = '{10'h00A, 10'h064, 10'h190, 10'h320};
		for (int i = 0; i < 4; i++) begin
			bus(1, `AXR_IDX_SETUP, {i[1:0], 6'h00});
			settle();
			chk({rs, sps}, {i[1:0], t[i]});
		end
		for (int i = 0; i < 8; i++) begin
			r = (i > 4) ? 3'h4 : i[2:0];
			bus(1, `AXR_IDX_SETUP, {2'h3, r, i[2:0]});
			settle();
			chk(gs, i[2:0]);
			chk(gv, i == 7 ? 0 : 1 << i);
			chk(gr, i == 7);
			chk({rf, rr}, {r, 1'b0});
			bus(0, `AXR_IDX_SETUP, 8'h00);
			chk(rv, {2'h3, r, i[2:0]});
		end
	endtask
	task t_mux;
		for (int c = 0; c < 16; c++) begin
			bus(1, `AXR_IDX_INPUT_SEL, {c[3:0], 4'hF - c[3:0]});
			settle();
			chk({ps, pi}, ex(c[3:0]));
			chk({ns, ni}, ex(4'hF - c[3:0]));
			bus(0, `AXR_IDX_INPUT_SEL, 8'h00);
			chk(rv, {c[3:0], 4'hF - c[3:0]});
		end
	endtask
	task t_refuse;
		bus(1, 8'hFF, 8'h5A);
		bus(0, 8'hFF, 8'h00);
		chk(rv, 8'h00);
		be <= 4'h0;
		bus(1, `AXR_IDX_SETUP, 8'h3F);
		be <= 4'h1;
		bus(0, `AXR_IDX_SETUP, 8'h00);
		chk(rv, 8'hE7);
	endtask
	// ==========================================================
	// clock, reset and sequence
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{nrst, rd_s, wr_s, adr, wd, gin} = '0;
		be = 4'h1;
		n_errors = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_gpio();
		t_setup();
		t_mux();
		t_refuse();
		end_sim();
	end
endmodule // axr_regs_tb
`default_nettype wire
